// >>> src/gdw_top.sv
// gpio-driven watchdog: level/direction registers, led mirrors and timer
// assumes an i/o register port synchronous to CORE_CLK, answering reads next cycle
`timescale 1ns/100ps
module gdw_top #(
   parameter longint P_100MS = gdw_pkg::CYC_100MS,
   parameter longint P_1S    = gdw_pkg::CYC_1S,
   parameter longint P_10S   = gdw_pkg::CYC_10S,
   parameter longint P_1MIN  = gdw_pkg::CYC_1MIN
) (
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   // register port
   input  wire gdw_pkg::gdw_req_t IO_REQ,
   output logic [31:0]            IO_RDATA,
   output logic                   IO_RVALID,
   // pins toward the timer component and leds
   output gdw_pkg::gdw_ctl_t      DOG_PINS,
   output logic [3:0]             DOG_PINS_OE_N,
   output logic                   LED1_ON,
   output logic                   LED7_ON,
   output logic                   SYS_RESET
);
   import gdw_pkg::*;

   logic rst_s1;
   logic rst_s2;
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   typedef struct packed {
      logic [31:0] dir_two;
      logic [31:0] lvl_two;
      logic [31:0] dir_three;
      logic [31:0] lvl_three;
      logic [31:0] rdata;
      logic        rvalid;
      gdw_ctl_t    pins;
      logic [3:0]  oe_n;
      logic        led1;
      logic        led7;
   } gdw_st_t;

   gdw_st_t st_reg;
   gdw_st_t st_next;
   gdw_ctl_t comp_in;
   logic expire;

   always_comb begin
      st_next = st_reg;
      st_next.rvalid = IO_REQ.rd;
      if (IO_REQ.wr) begin
         case (IO_REQ.addr)
            OFS_DIR_TWO:   st_next.dir_two   = IO_REQ.wdata;
            OFS_LVL_TWO:   st_next.lvl_two   = IO_REQ.wdata;
            OFS_DIR_THREE: st_next.dir_three = IO_REQ.wdata;
            OFS_LVL_THREE: st_next.lvl_three = IO_REQ.wdata;
            default: ;
         endcase
      end
      case (IO_REQ.addr)
         OFS_DIR_TWO:   st_next.rdata = st_reg.dir_two;
         OFS_LVL_TWO:   st_next.rdata = st_reg.lvl_two;
         OFS_DIR_THREE: st_next.rdata = st_reg.dir_three;
         OFS_LVL_THREE: st_next.rdata = st_reg.lvl_three;
         default:       st_next.rdata = 32'h0;
      endcase
      if (!IO_REQ.rd)
         st_next.rdata = 32'h0;
      // pin levels follow registers; 0 in direction means output
      st_next.pins.arm_n    = st_next.lvl_two[BIT_ARM] | st_next.dir_two[BIT_ARM];
      st_next.pins.sel_low  = st_next.lvl_two[BIT_SEL_LOW];
      st_next.pins.sel_high = st_next.lvl_two[BIT_SEL_HIGH];
      st_next.pins.kick     = st_next.lvl_three[BIT_KICK];
      st_next.oe_n = {st_next.dir_three[BIT_KICK_DIR], st_next.dir_two[2:0]};
      st_next.led1 = !st_next.lvl_two[BIT_SEL_HIGH];
      st_next.led7 = !st_next.lvl_three[BIT_KICK];
   end

   always_ff @(posedge CORE_CLK or negedge rst_s2) begin
      if (!rst_s2) begin
         st_reg <= '0;
         st_reg.dir_two   <= RST_DIR;
         st_reg.dir_three <= RST_DIR;
         st_reg.lvl_two   <= RST_LVL_TWO;
         st_reg.lvl_three <= RST_LVL_THREE;
         st_reg.pins.arm_n <= 1'b1;
         st_reg.led1 <= 1'b1;
         st_reg.led7 <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // the component sees each select inverted
   always_comb begin
      comp_in = st_reg.pins;
      comp_in.sel_low  = !st_reg.pins.sel_low;
      comp_in.sel_high = !st_reg.pins.sel_high;
   end

   gdw_timer #(
      .P_100MS (P_100MS),
      .P_1S    (P_1S),
      .P_10S   (P_10S),
      .P_1MIN  (P_1MIN)
   ) u_timer (
      .clk    (CORE_CLK),
      .rst_n  (rst_s2),
      .ctl    (comp_in),
      .expire (expire)
   );

   assign IO_RDATA      = st_reg.rdata;
   assign IO_RVALID     = st_reg.rvalid;
   assign DOG_PINS      = st_reg.pins;
   assign DOG_PINS_OE_N = st_reg.oe_n;
   assign LED1_ON       = st_reg.led1;
   assign LED7_ON       = st_reg.led7;
   assign SYS_RESET     = expire;

   property p_led7;
      @(posedge CORE_CLK) disable iff (!rst_s2) LED7_ON == !st_reg.lvl_three[BIT_KICK];
   endproperty
   a_led7: assert property (p_led7) else $error("led7 not inverse of kick");

   property p_led1;
      @(posedge CORE_CLK) disable iff (!rst_s2) LED1_ON == !st_reg.lvl_two[BIT_SEL_HIGH];
   endproperty
   a_led1: assert property (p_led1) else $error("led1 not inverse of select");

   property p_kick_write;
      @(posedge CORE_CLK) disable iff (!rst_s2)
         (IO_REQ.wr && IO_REQ.addr == OFS_LVL_THREE)
         |=> DOG_PINS.kick == $past(IO_REQ.wdata[BIT_KICK]);
   endproperty
   a_kick_write: assert property (p_kick_write) else $error("kick pin not updated");

   property p_sel_write;
      @(posedge CORE_CLK) disable iff (!rst_s2)
         (IO_REQ.wr && IO_REQ.addr == OFS_LVL_TWO)
         |=> DOG_PINS.sel_high == $past(IO_REQ.wdata[BIT_SEL_HIGH])
             && DOG_PINS.sel_low == $past(IO_REQ.wdata[BIT_SEL_LOW]);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("select pins not updated");

   property p_invert;
      @(posedge CORE_CLK) disable iff (!rst_s2) comp_in.sel_low != DOG_PINS.sel_low;
   endproperty
   a_invert: assert property (p_invert) else $error("select not inverted");

   property p_arm_reset;
      @(posedge CORE_CLK) $rose(rst_s2) |-> DOG_PINS.arm_n && DOG_PINS_OE_N == 4'h0;
   endproperty
   a_arm_reset: assert property (p_arm_reset) else $error("bad reset state");

   property p_invert_high;
      @(posedge CORE_CLK) disable iff (!rst_s2) comp_in.sel_high != DOG_PINS.sel_high;
   endproperty
   a_invert_high: assert property (p_invert_high) else $error("sel high not inverted");

   property p_arm_write;
      @(posedge CORE_CLK) disable iff (!rst_s2)
         (IO_REQ.wr && IO_REQ.addr == OFS_LVL_TWO && !st_reg.dir_two[BIT_ARM])
         |=> DOG_PINS.arm_n == $past(IO_REQ.wdata[BIT_ARM]);
   endproperty
   a_arm_write: assert property (p_arm_write) else $error("arm pin not updated");

   property p_oe_two;
      @(posedge CORE_CLK) disable iff (!rst_s2)
         (IO_REQ.wr && IO_REQ.addr == OFS_DIR_TWO)
         |=> DOG_PINS_OE_N[2:0] == $past(IO_REQ.wdata[2:0]);
   endproperty
   a_oe_two: assert property (p_oe_two) else $error("low enables not updated");

   property p_oe_three;
      @(posedge CORE_CLK) disable iff (!rst_s2)
         (IO_REQ.wr && IO_REQ.addr == OFS_DIR_THREE)
         |=> DOG_PINS_OE_N[3] == $past(IO_REQ.wdata[BIT_KICK_DIR]);
   endproperty
   a_oe_three: assert property (p_oe_three) else $error("kick enable not updated");

   sequence s_rd_lvl_two;
      IO_REQ.rd && IO_REQ.addr == OFS_LVL_TWO;
   endsequence

   sequence s_ans_lvl_two;
      IO_RVALID && IO_RDATA == $past(st_reg.lvl_two);
   endsequence

   property p_rd_lvl_two;
      @(posedge CORE_CLK) disable iff (!rst_s2) s_rd_lvl_two |=> s_ans_lvl_two;
   endproperty
   a_rd_lvl_two: assert property (p_rd_lvl_two) else $error("lvl2 read wrong");

   sequence s_rd_lvl_three;
      IO_REQ.rd && IO_REQ.addr == OFS_LVL_THREE;
   endsequence

   sequence s_ans_lvl_three;
      IO_RVALID && IO_RDATA == $past(st_reg.lvl_three);
   endsequence

   property p_rd_lvl_three;
      @(posedge CORE_CLK) disable iff (!rst_s2) s_rd_lvl_three |=> s_ans_lvl_three;
   endproperty
   a_rd_lvl_three: assert property (p_rd_lvl_three) else $error("lvl3 read wrong");

   property p_rd_valid;
      @(posedge CORE_CLK) disable iff (!rst_s2) IO_REQ.rd |=> IO_RVALID;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

   property p_rd_idle;
      @(posedge CORE_CLK) disable iff (!rst_s2) !IO_REQ.rd |=> !IO_RVALID && IO_RDATA == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
endmodule // gdw_top

// >>> src/gdw_pkg.sv
// package: register map, pin positions, timeout constants of the gpio-driven watchdog
// assumes a single 100 MHz core clock and an i/o-style register port
// How it works
// - armed, select pins 11/10/01/00 give 100 ms, 1 s, 10 s, 1 min; disarmed they are ignored.
// - while armed, reset is asserted if the kick line has not changed within the set period.
// - the kick line is bit 23 of the bank-three level register at offset 48h.
// - the upper select line is bit 3 of the bank-two level register at offset 38h.
// - post code led1 shows the inverse of the upper select bit.
// - post code led7 shows the inverse of the kick bit.
// - each select level reaches the timer component inverted.
// - the four control lines come up as outputs after reset with no software action.
// - the active-low arm bit is bit 0 at 38h and resets to one, keeping the timer disarmed.
// - the lower select line sits in bit 1 of the bank-two level register.
package gdw_pkg;
   localparam logic [7:0] OFS_DIR_TWO   = 8'h34;
   localparam logic [7:0] OFS_LVL_TWO   = 8'h38;
   localparam logic [7:0] OFS_DIR_THREE = 8'h44;
   localparam logic [7:0] OFS_LVL_THREE = 8'h48;
   localparam int BIT_ARM      = 0;
   localparam int BIT_SEL_LOW  = 1;
   localparam int BIT_SEL_HIGH = 3;
   localparam int BIT_KICK     = 23;
   localparam int BIT_KICK_DIR = 7;
   localparam logic [31:0] RST_DIR  = 32'h0000_0000;
   localparam logic [31:0] RST_LVL_TWO   = 32'h0000_0001;
   localparam logic [31:0] RST_LVL_THREE = 32'h0000_0000;
   localparam longint CLK_HZ   = 100_000_000;
   localparam longint T_100MS  = 100;
   localparam longint T_1S     = 1;
   localparam longint T_10S    = 10;
   localparam longint T_1MIN   = 1;
   localparam longint CYC_100MS = CLK_HZ * T_100MS / 1000;
   localparam longint CYC_1S    = CLK_HZ * T_1S;
   localparam longint CYC_10S   = CLK_HZ * T_10S;
   localparam longint CYC_1MIN  = CLK_HZ * 60 * T_1MIN;
   localparam int RESET_PULSE = 16;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } gdw_req_t;

   typedef struct packed {
      logic        arm_n;
      logic        sel_low;
      logic        sel_high;
      logic        kick;
   } gdw_ctl_t;
endpackage

// >>> src/gdw_timer.sv
// timer core: counts the selected period, restarts on kick change, pulses reset on expiry
// assumes control levels already registered in the core clock domain
`timescale 1ns/100ps
module gdw_timer #(
   parameter longint P_100MS = gdw_pkg::CYC_100MS,
   parameter longint P_1S    = gdw_pkg::CYC_1S,
   parameter longint P_10S   = gdw_pkg::CYC_10S,
   parameter longint P_1MIN  = gdw_pkg::CYC_1MIN
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   // inverted selects as seen by the component, arm and kick
   input  wire gdw_pkg::gdw_ctl_t ctl,
   // reset request
   output logic                 expire
);
   import gdw_pkg::*;

   localparam longint P_LIM = 64'h0000_0100_0000_0000;

   // refuse periods the 40-bit counter cannot hold
   if (P_100MS < 1 || P_1S < 1 || P_10S < 1 || P_1MIN < 1 ||
       P_100MS >= P_LIM || P_1S >= P_LIM || P_10S >= P_LIM || P_1MIN >= P_LIM) begin : g_bad_period
      $error("gdw_timer: bad period");
   end

   typedef struct packed {
      logic [39:0] cnt;
      logic        kick_d;
      logic        armed_d;
      logic [4:0]  pulse;
   } gdw_tst_t;

   gdw_tst_t st_reg;
   gdw_tst_t st_next;
   logic [39:0] period;

   always_comb begin
      // selects arrive inverted, so 00 here means both pins high
      case ({ctl.sel_high, ctl.sel_low})
         2'b00:   period = 40'(P_100MS);
         2'b01:   period = 40'(P_1S);
         2'b10:   period = 40'(P_10S);
         default: period = 40'(P_1MIN);
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.kick_d = ctl.kick;
      st_next.armed_d = !ctl.arm_n;
      if (st_reg.pulse != 5'h00)
         st_next.pulse = st_reg.pulse - 5'h01;
      if (ctl.arm_n) begin
         st_next.cnt = 40'h0;
      end else if (!st_reg.armed_d || ctl.kick != st_reg.kick_d) begin
         st_next.cnt = period - 40'h1;
      end else if (st_reg.cnt == 40'h0) begin
         st_next.pulse = 5'(RESET_PULSE);
         st_next.cnt = period - 40'h1;
      end else begin
         st_next.cnt = st_reg.cnt - 40'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         expire <= 1'b0;
      else
         expire <= (st_next.pulse != 5'h00);
   end

   property p_disarm_clear;
      @(posedge clk) disable iff (!rst_n) ctl.arm_n |=> st_reg.cnt == 40'h0;
   endproperty
   a_disarm_clear: assert property (p_disarm_clear) else $error("count not cleared");

   property p_kick_restart;
      @(posedge clk) disable iff (!rst_n)
         (!ctl.arm_n && st_reg.armed_d && ctl.kick != st_reg.kick_d)
         |=> st_reg.cnt == $past(period) - 40'h1;
   endproperty
   a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart");

   property p_expire;
      @(posedge clk) disable iff (!rst_n)
         (!ctl.arm_n && st_reg.armed_d && ctl.kick == st_reg.kick_d && st_reg.cnt == 0)
         |=> st_reg.pulse == 5'(RESET_PULSE) ##0 expire;
   endproperty
   a_expire: assert property (p_expire) else $error("no reset on expiry");

   property p_no_reset_disarmed;
      @(posedge clk) disable iff (!rst_n)
         (ctl.arm_n && st_reg.pulse == 0) [*2] |=> !expire;
   endproperty
   a_no_reset_disarmed: assert property (p_no_reset_disarmed)
      else $error("reset while disarmed");
endmodule // gdw_timer

// >>> bench/gdw_sw_model.sv
// partner: software reaching the watchdog by whole-word reads and writes
// assumes one calling process, each call starting just after a clock edge
`timescale 1ns/100ps
module gdw_sw_model
   import gdw_pkg::*;
(
   // clock
   input  wire logic clk,
   // register port
   output gdw_req_t  req
);
   logic [31:0] sh [logic [7:0]];
   logic [31:0] exp_q [$];
   initial begin
      req = '0;
      sh  = '{8'h34: 32'h0, 8'h38: 32'h1, 8'h44: 32'h0, 8'h48: 32'h0};
   end
   // request held through its sampling edge only
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      if (sh.exists(a)) sh[a] = d;
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      exp_q.push_back(sh.exists(a) ? sh[a] : 32'h0);
      acc(1'b0, a, 32'h0);
   endtask
   task automatic rmw(input logic [7:0] a, input int b, input logic v);
      logic [31:0] d;
      rd(a);
      d    = sh[a];
      d[b] = v;
      wr(a, d);
   endtask
   task automatic kick();
      wr(OFS_LVL_THREE, sh[OFS_LVL_THREE] ^ (32'h1 << BIT_KICK));
   endtask
   // outputs, disarm, select, then arm
   task automatic arm(input logic [1:0] s);
      for (int i = 0; i < 3; i++) rmw(OFS_DIR_TWO, i, 1'b0);
      rmw(OFS_DIR_THREE, BIT_KICK_DIR, 1'b0);
      rmw(OFS_LVL_TWO, BIT_ARM, 1'b1);
      rmw(OFS_LVL_TWO, BIT_SEL_LOW, s[0]);
      rmw(OFS_LVL_TWO, BIT_SEL_HIGH, s[1]);
      rmw(OFS_LVL_TWO, BIT_ARM, 1'b0);
   endtask
endmodule // gdw_sw_model

// >>> bench/gdw_top_tb_top.sv
// bench: drives the watchdog through the software model, checks pins, leds, reset
// assumes reads answer one cycle after the request
`timescale 1ns/100ps
module gdw_top_tb_top;
   import gdw_pkg::*;
   localparam int         PER [4] = '{80, 60, 40, 20};
   localparam logic [7:0] ADR [5] = '{8'h34, 8'h38, 8'h44, 8'h48, 8'h40};
   logic        core_clk;
   logic        rst_n;
   gdw_req_t    io_req;
   logic [31:0] io_rdata;
   logic        io_rvalid;
   gdw_ctl_t    pins_q;
   logic [3:0]  oe_n;
   logic        led1_on;
   logic        led7_on;
   logic        sys_reset;
   int          err_total = 0;
   int          tests_run = 0;
   int          run = 0;
   int          fires = 0;
   logic [31:0] rnd = 32'h47e47ee0;

   gdw_top #(.P_100MS(20), .P_1S(40), .P_10S(60), .P_1MIN(80)) dut (
      .CORE_CLK(core_clk), .RST_N(rst_n), .IO_REQ(io_req), .IO_RDATA(io_rdata),
      .IO_RVALID(io_rvalid), .DOG_PINS(pins_q), .DOG_PINS_OE_N(oe_n),
      .LED1_ON(led1_on), .LED7_ON(led7_on), .SYS_RESET(sys_reset));
   gdw_sw_model sw (.clk(core_clk), .req(io_req));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic pins();
      logic [31:0] l2, l3, d2, d3, ep;
      l2 = sw.sh[OFS_LVL_TWO];
      l3 = sw.sh[OFS_LVL_THREE];
      d2 = sw.sh[OFS_DIR_TWO];
      d3 = sw.sh[OFS_DIR_THREE];
      ep = {28'h0, l2[0] | d2[0], l2[1], l2[3], l3[23]};
      chk("pins", ep, {28'h0, pins_q});
      chk("oe_n", {28'h0, d3[7], d2[2:0]}, {28'h0, oe_n});
      chk("led1", {31'h0, ~l2[3]}, {31'h0, led1_on});
      chk("led7", {31'h0, ~l3[23]}, {31'h0, led7_on});
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // read results against noted values, reset pulse width and count
   always @(posedge core_clk) begin
      if (io_rvalid === 1'b1) begin
         if (sw.exp_q.size() > 0) chk("rdata", sw.exp_q.pop_front(), io_rdata);
         else chk("rvalid", 0, 1);
      end
      if (sys_reset === 1'b1) begin
         if (run == 0) fires <= fires + 1;
         run <= run + 1;
      end else if (run != 0) begin
         chk("pulse", RESET_PULSE, run);
         run <= 0;
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #300000;
      err_total++;
      test_done();
   end
   initial begin
      int w, f;
      rst_n = 1'b0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      pins();
      for (int i = 0; i < 5; i++) sw.rd(ADR[i]);
      // random levels with the timer kept off
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         sw.wr(ADR[i % 5], rnd | 32'h1);
         pins();
         sw.rd(ADR[(i + 3) % 5]);
         chk("idle", 0, fires);
      end
      for (int s = 0; s < 4; s++) begin
         sw.arm(s[1:0]);
         pins();
         f = fires;
         for (int k = 0; k < 4; k++) begin
            repeat (PER[s] / 2) @(posedge core_clk);
            sw.kick();
            chk("early", f, fires);
         end
         w = 0;
         while (sys_reset !== 1'b1 && w < 200) begin
            @(posedge core_clk);
            w++;
         end
         chk("expire", 1, {31'h0, w >= PER[s] - 1 && w <= PER[s] + 5});
         sw.rmw(OFS_LVL_TWO, BIT_ARM, 1'b1);
         f = fires;
         repeat (120) @(posedge core_clk);
         chk("disarmed", f, fires);
      end
      chk("reads", 0, sw.exp_q.size());
      test_done();
   end
endmodule // gdw_top_tb_top
